//--- dv/cpu_alu_status_datapath_tb.sv
// Self-checking bench of the ALU datapath
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_status_datapath_tb
    import alu_status_pkg::*;
;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, OP_SRC, BIT_RESULT;
    logic [7:0] PRIMARY_OUT, SECOND_OUT, STATUS_OUT, BANK_BASE;
    logic SFR_WR, SFR_RD, SFR_HIT, OP_VALID, JUMP_TAKEN;
    logic [2:0] OP_BIT;
    alu_op_t OP_CODE;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    alu_op_t lops[8] = '{OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RL, OP_RR, OP_INC, OP_DEC};
    logic [7:0] lexp[8] = '{8'h24, 8'hBD, 8'h99, 8'h5A, 8'h4B, 8'hD2, 8'hA6, 8'hA4};
    cpu_alu_status_datapath DUT (
        .MCLK(MCLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_HIT(SFR_HIT), .SFR_RDATA(SFR_RDATA),
        .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_SRC(OP_SRC), .OP_BIT(OP_BIT),
        .BIT_RESULT(BIT_RESULT), .JUMP_TAKEN(JUMP_TAKEN), .PRIMARY_OUT(PRIMARY_OUT),
        .SECOND_OUT(SECOND_OUT), .STATUS_OUT(STATUS_OUT), .BANK_BASE(BANK_BASE)
    );
    sfr_decoder_model u_model (
        .MCLK(MCLK), .SFR_HIT(SFR_HIT), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .OP_SRC(OP_SRC), .OP_BIT(OP_BIT)
    );
    always #2.5 MCLK = ~MCLK;
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic h;
        u_model.req(1'b1, 1'b0, a, d, h);
        chk({7'h00, h}, {7'h00, (a == 8'hD0) || (a == 8'hE0) || (a == 8'hF0)}, "hit");
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic h;
        u_model.req(1'b0, 1'b1, a, 8'h00, h);
        chk(SFR_RDATA, e, "read");
        chk({7'h00, h}, {7'h00, (a == 8'hD0) || (a == 8'hE0) || (a == 8'hF0)}, "hit");
    endtask
    task automatic t_reset();
        chk(PRIMARY_OUT, 8'h00, "primary");
        chk(SECOND_OUT, 8'h00, "second");
        chk(STATUS_OUT, 8'h00, "status");
        chk(BANK_BASE, 8'h00, "bank");
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(8'hF0, 8'h5A);
        rd(8'hF0, 8'h5A);
        rd(8'h80, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hD0, 8'(i << 3));
            chk(BANK_BASE, 8'(i * 8), "bank");
        end
        $display("test registers done");
    endtask
    task automatic t_arith();
        wr(8'hD0, 8'h22);
        wr(8'hE0, 8'h7F);
        chk(STATUS_OUT, 8'h23, "parity");
        u_model.op(OP_ADD, 8'h01, 3'h0);
        chk(PRIMARY_OUT, 8'h80, "sum");
        chk(STATUS_OUT, 8'h67, "flags");
        wr(8'hD0, 8'h00);
        wr(8'hE0, 8'h10);
        wr(8'hF0, 8'h20);
        u_model.op(OP_MUL, 8'h00, 3'h0);
        chk(SECOND_OUT, 8'h02, "product");
        chk(PRIMARY_OUT, 8'h00, "product low");
        chk(STATUS_OUT, 8'h04, "mul flags");
        wr(8'hE0, 8'h25);
        wr(8'hF0, 8'h07);
        u_model.op(OP_DIV, 8'h00, 3'h0);
        chk(PRIMARY_OUT, 8'h05, "quotient");
        chk(SECOND_OUT, 8'h02, "remainder");
        wr(8'hF0, 8'h00);
        u_model.op(OP_DIV, 8'h00, 3'h0);
        chk(STATUS_OUT, 8'h04, "div zero");
        chk(PRIMARY_OUT, 8'h05, "kept");
        $display("test arithmetic done");
    endtask
    task automatic t_logic();
        for (int i = 0; i < 8; i++)
        begin
            wr(8'hE0, 8'hA5);
            u_model.op(lops[i], 8'h3C, 3'h0);
            chk(PRIMARY_OUT, lexp[i], "logic");
        end
        $display("test logic done");
    endtask
    task automatic t_bits();
        u_model.op(OP_JBC, 8'h08, 3'h3);
        chk(BIT_RESULT, 8'h00, "cleared");
        chk({7'h00, JUMP_TAKEN}, 8'h01, "jump");
        @(negedge MCLK);
        chk({7'h00, JUMP_TAKEN}, 8'h00, "pulse");
        u_model.op(OP_BSET, 8'h00, 3'h7);
        chk(BIT_RESULT, 8'h80, "set");
        wr(8'hE0, 8'h00);
        wr(8'hD0, 8'h80);
        u_model.op(OP_MOVC_OUT, 8'h00, 3'h2);
        chk(BIT_RESULT, 8'h04, "to bit");
        u_model.op(OP_MOVC_IN, 8'h00, 3'h2);
        chk(STATUS_OUT, 8'h00, "to carry");
        $display("test bits done");
    endtask
    task automatic t_flags();
        wr(8'hD0, 8'h81);
        chk(STATUS_OUT, 8'h80, "parity write");
        wr(8'hE0, 8'h50);
        u_model.op(OP_SUBB, 8'h20, 3'h0);
        chk(PRIMARY_OUT, 8'h2F, "difference");
        chk(STATUS_OUT, 8'h41, "sub flags");
        u_model.op(OP_CSET, 8'h00, 3'h0);
        chk(STATUS_OUT, 8'hC1, "carry set");
        u_model.op(OP_ADDC, 8'hD0, 3'h0);
        chk(PRIMARY_OUT, 8'h00, "sum carry");
        chk(STATUS_OUT, 8'hC0, "addc flags");
        u_model.op(OP_CCPL, 8'h00, 3'h0);
        chk(STATUS_OUT, 8'h40, "carry flip");
        wr(8'hD0, 8'h00);
        wr(8'hE0, 8'h9B);
        u_model.op(OP_DA, 8'h00, 3'h0);
        chk(PRIMARY_OUT, 8'h01, "adjust");
        chk(STATUS_OUT, 8'h81, "adjust carry");
        u_model.op(OP_CCLR, 8'h00, 3'h0);
        chk(STATUS_OUT, 8'h01, "carry clear");
        u_model.op(OP_CMP, 8'h05, 3'h0);
        chk(PRIMARY_OUT, 8'h01, "compare kept");
        chk(STATUS_OUT, 8'h81, "compare carry");
        u_model.op(OP_RLC, 8'h00, 3'h0);
        chk(PRIMARY_OUT, 8'h03, "rotate in");
        chk(STATUS_OUT, 8'h00, "rotate out");
        u_model.op(OP_RRC, 8'h00, 3'h0);
        chk(PRIMARY_OUT, 8'h01, "rotate right");
        rd(8'hD0, 8'h81);
        rd(8'hE0, 8'h01);
        u_model.op(OP_JNB, 8'hF7, 3'h3);
        chk({7'h00, JUMP_TAKEN}, 8'h01, "jump clear bit");
        chk(BIT_RESULT, 8'hF7, "jump byte");
        u_model.op(OP_JNB, 8'h08, 3'h3);
        chk({7'h00, JUMP_TAKEN}, 8'h00, "no jump");
        u_model.op(OP_BCLR, 8'hFF, 3'h0);
        chk(BIT_RESULT, 8'hFE, "bit clear");
        u_model.op(OP_BCPL, 8'h0F, 3'h7);
        chk(BIT_RESULT, 8'h8F, "bit flip");
        $display("test flags done");
    endtask
    task automatic t_midreset();
        wr(8'hD0, 8'h18);
        wr(8'hF0, 8'h33);
        @(negedge MCLK);
        RST_N = 1'b0;
        repeat (2) @(negedge MCLK);
        RST_N = 1'b1;
        chk(STATUS_OUT, 8'h00, "status after reset");
        chk(SECOND_OUT, 8'h00, "second after reset");
        chk(BANK_BASE, 8'h00, "bank after reset");
        chk(BIT_RESULT, 8'h00, "bits after reset");
        @(negedge MCLK);
        chk(PRIMARY_OUT, 8'h00, "primary after reset");
        $display("test mid-run reset done");
    endtask
    initial
    begin
        repeat (12) @(negedge MCLK);
        RST_N = 1'b1;
        t_reset();
        t_regs();
        t_arith();
        t_logic();
        t_bits();
        t_flags();
        t_midreset();
        give_verdict();
    end
endmodule // cpu_alu_status_datapath_tb
`default_nettype wire

//--- dv/sfr_decoder_model.sv
// Decoder model driving register and operation requests
`timescale 1ns/1ps
`default_nettype none
module sfr_decoder_model
    import alu_status_pkg::*;
(
    input wire logic MCLK,
    input wire logic SFR_HIT,
    output logic [7:0] SFR_ADDR,
    output logic SFR_WR,
    output logic [7:0] SFR_WDATA,
    output logic SFR_RD,
    output logic OP_VALID,
    output var alu_op_t OP_CODE,
    output logic [7:0] OP_SRC,
    output logic [2:0] OP_BIT
);
    initial
    begin
        {SFR_ADDR, SFR_WR, SFR_WDATA, SFR_RD, OP_VALID, OP_SRC, OP_BIT} = '0;
        OP_CODE = OP_NOP;
    end
    // Released strobes drop to 0; address and data lines show the inverse of the last value
    task automatic req(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        output logic hit);
        @(negedge MCLK);
        {SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA} <= {w, r, a, d};
        @(posedge MCLK);
        hit = SFR_HIT;
        @(negedge MCLK);
        {SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA} <= {1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic op(input alu_op_t c, input logic [7:0] s, input logic [2:0] b);
        @(negedge MCLK);
        {OP_VALID, OP_SRC, OP_BIT} <= {1'b1, s, b};
        OP_CODE <= c;
        @(negedge MCLK);
        {OP_VALID, OP_SRC, OP_BIT} <= {1'b0, ~s, ~b};
        OP_CODE <= OP_NOP;
    endtask
endmodule // sfr_decoder_model
`default_nettype wire

//--- verilog/alu_status_pkg.sv
// Operation codes of the ALU datapath
package alu_status_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'b00000, OP_ADD = 5'b00001, OP_ADDC = 5'b00010, OP_SUBB = 5'b00011,
        OP_MUL = 5'b00100, OP_DIV = 5'b00101, OP_INC = 5'b00110, OP_DEC = 5'b00111,
        OP_DA = 5'b01000, OP_CMP = 5'b01001, OP_AND = 5'b01010, OP_OR = 5'b01011,
        OP_XOR = 5'b01100, OP_CPL = 5'b01101, OP_RL = 5'b01110, OP_RLC = 5'b01111,
        OP_RR = 5'b10000, OP_RRC = 5'b10001, OP_BSET = 5'b10010, OP_BCLR = 5'b10011,
        OP_BCPL = 5'b10100, OP_JNB = 5'b10101, OP_JBC = 5'b10110, OP_MOVC_IN = 5'b10111,
        OP_MOVC_OUT = 5'b11000, OP_CCLR = 5'b11001, OP_CSET = 5'b11010, OP_CCPL = 5'b11011
    } alu_op_t;
endpackage

//--- verilog/alu_status_regs.svh
// Register addresses, field positions, reset values and constants of the ALU datapath
`ifndef ALU_STATUS_REGS_SVH
`define ALU_STATUS_REGS_SVH
`define ADDR_STATUS_WORD 8'hD0
`define ADDR_PRIMARY 8'hE0
`define ADDR_SECOND 8'hF0
`define RST_BYTE 8'h00
`define BIT_CARRY 7
`define BIT_HALF_CARRY 6
`define BIT_USER_ZERO 5
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_SIGNED_EXCESS 2
`define BIT_USER_ONE 1
`define BIT_PARITY 0
`define BANK0_BASE 8'h00
`define BANK1_BASE 8'h08
`define BANK2_BASE 8'h10
`define BANK3_BASE 8'h18
`define DA_LIMIT 4'h9
`define DA_LOW_ADJ 9'h006
`define DA_HIGH_ADJ 9'h060
`endif

//--- verilog/cpu_alu_status_datapath.sv
// ALU datapath with primary operand, second operand and status word registers
// Behaviour
// - Primary, second operand, status word at 0xE0, 0xF0, 0xD0; 8 bits, reset 0x00.
// - Second operand register holds operand and result of multiply and divide.
// - Add, subtract, multiply, divide, increment, decrement, decimal adjust, compare.
// - Bitwise AND, OR, XOR, complement and rotates on bytes.
// - Boolean bit set, clear, complement, jump tests, carry moves.
// - Status word bits carry, half carry, flag0, bank hi, bank lo, excess, flag1, parity.
// - Bank select picks bank base 0x00, 0x08, 0x10 or 0x18.
// - User flags change only by software writes.
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_regs.svh"
module cpu_alu_status_datapath
    import alu_status_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_RD,
    output logic SFR_HIT,
    output logic [7:0] SFR_RDATA,
    input wire logic OP_VALID,
    input wire alu_op_t OP_CODE,
    input wire logic [7:0] OP_SRC,
    input wire logic [2:0] OP_BIT,
    output logic [7:0] BIT_RESULT,
    output logic JUMP_TAKEN,
    output logic [7:0] PRIMARY_OUT,
    output logic [7:0] SECOND_OUT,
    output logic [7:0] STATUS_OUT,
    output logic [7:0] BANK_BASE
);
    logic [7:0] acc_r, acc_nxt, b_r, b_nxt, psw_r, psw_nxt, rdata_r, rdata_nxt;
    logic [7:0] bres_r, bres_nxt, base_r, base_nxt;
    logic jump_r, jump_nxt, par_r, par_nxt;
    logic [8:0] sum9, dif9, da1, da2;
    logic [4:0] hsum, hdif;
    logic [15:0] prod;
    logic [7:0] mask;
    logic cin, op_go;

    assign op_go = OP_VALID && !SFR_WR;
    assign cin = psw_r[`BIT_CARRY];
    assign SFR_HIT = (SFR_ADDR == `ADDR_PRIMARY) || (SFR_ADDR == `ADDR_SECOND)
        || (SFR_ADDR == `ADDR_STATUS_WORD);

    always_comb
    begin
        acc_nxt = acc_r;
        b_nxt = b_r;
        psw_nxt = psw_r;
        bres_nxt = bres_r;
        jump_nxt = 1'b0;
        rdata_nxt = rdata_r;
        mask = 8'h01 << OP_BIT;
        sum9 = {1'b0, acc_r} + {1'b0, OP_SRC} + {8'h00, cin && (OP_CODE == OP_ADDC)};
        hsum = {1'b0, acc_r[3:0]} + {1'b0, OP_SRC[3:0]} + {4'h0, cin && (OP_CODE == OP_ADDC)};
        dif9 = {1'b0, acc_r} - {1'b0, OP_SRC} - {8'h00, cin};
        hdif = {1'b0, acc_r[3:0]} - {1'b0, OP_SRC[3:0]} - {4'h0, cin};
        prod = {8'h00, acc_r} * {8'h00, b_r};
        da1 = {1'b0, acc_r};
        if ((acc_r[3:0] > `DA_LIMIT) || psw_r[`BIT_HALF_CARRY])
            da1 = da1 + `DA_LOW_ADJ;
        da2 = da1;
        if ((da1[7:4] > `DA_LIMIT) || da1[8] || cin)
            da2 = da1 + `DA_HIGH_ADJ;
        if (SFR_WR)
        begin
            if (SFR_ADDR == `ADDR_PRIMARY)
                acc_nxt = SFR_WDATA;
            if (SFR_ADDR == `ADDR_SECOND)
                b_nxt = SFR_WDATA;
            if (SFR_ADDR == `ADDR_STATUS_WORD)
                psw_nxt = SFR_WDATA;
        end
        else if (OP_VALID)
        begin
            unique case (OP_CODE)
                OP_ADD, OP_ADDC:
                begin
                    acc_nxt = sum9[7:0];
                    psw_nxt[`BIT_CARRY] = sum9[8];
                    psw_nxt[`BIT_HALF_CARRY] = hsum[4];
                    psw_nxt[`BIT_SIGNED_EXCESS] = (acc_r[7] == OP_SRC[7]) && (sum9[7] != acc_r[7]);
                end
                OP_SUBB:
                begin
                    acc_nxt = dif9[7:0];
                    psw_nxt[`BIT_CARRY] = dif9[8];
                    psw_nxt[`BIT_HALF_CARRY] = hdif[4];
                    psw_nxt[`BIT_SIGNED_EXCESS] = (acc_r[7] != OP_SRC[7]) && (dif9[7] != acc_r[7]);
                end
                OP_MUL:
                begin
                    acc_nxt = prod[7:0];
                    b_nxt = prod[15:8];
                    psw_nxt[`BIT_CARRY] = 1'b0;
                    psw_nxt[`BIT_SIGNED_EXCESS] = (prod[15:8] != 8'h00);
                end
                OP_DIV:
                begin
                    psw_nxt[`BIT_CARRY] = 1'b0;
                    psw_nxt[`BIT_SIGNED_EXCESS] = (b_r == 8'h00);
                    if (b_r != 8'h00)
                    begin
                        acc_nxt = acc_r / b_r;
                        b_nxt = acc_r % b_r;
                    end
                end
                OP_INC: acc_nxt = acc_r + 8'h01;
                OP_DEC: acc_nxt = acc_r - 8'h01;
                OP_DA:
                begin
                    acc_nxt = da2[7:0];
                    psw_nxt[`BIT_CARRY] = cin || da1[8] || da2[8];
                end
                OP_CMP: psw_nxt[`BIT_CARRY] = (acc_r < OP_SRC);
                OP_AND: acc_nxt = acc_r & OP_SRC;
                OP_OR: acc_nxt = acc_r | OP_SRC;
                OP_XOR: acc_nxt = acc_r ^ OP_SRC;
                OP_CPL: acc_nxt = ~acc_r;
                OP_RL: acc_nxt = {acc_r[6:0], acc_r[7]};
                OP_RR: acc_nxt = {acc_r[0], acc_r[7:1]};
                OP_RLC:
                begin
                    acc_nxt = {acc_r[6:0], cin};
                    psw_nxt[`BIT_CARRY] = acc_r[7];
                end
                OP_RRC:
                begin
                    acc_nxt = {cin, acc_r[7:1]};
                    psw_nxt[`BIT_CARRY] = acc_r[0];
                end
                OP_BSET: bres_nxt = OP_SRC | mask;
                OP_BCLR: bres_nxt = OP_SRC & ~mask;
                OP_BCPL: bres_nxt = OP_SRC ^ mask;
                OP_JNB:
                begin
                    bres_nxt = OP_SRC;
                    jump_nxt = !OP_SRC[OP_BIT];
                end
                OP_JBC:
                begin
                    bres_nxt = OP_SRC & ~mask;
                    jump_nxt = OP_SRC[OP_BIT];
                end
                OP_MOVC_IN: psw_nxt[`BIT_CARRY] = OP_SRC[OP_BIT];
                OP_MOVC_OUT: bres_nxt = cin ? (OP_SRC | mask) : (OP_SRC & ~mask);
                OP_CCLR: psw_nxt[`BIT_CARRY] = 1'b0;
                OP_CSET: psw_nxt[`BIT_CARRY] = 1'b1;
                OP_CCPL: psw_nxt[`BIT_CARRY] = !cin;
                default: ;
            endcase
        end
        psw_nxt[`BIT_PARITY] = 1'b0;
        par_nxt = ^acc_nxt;
        unique case (psw_nxt[`BIT_BANK_HI:`BIT_BANK_LO])
            2'b00: base_nxt = `BANK0_BASE;
            2'b01: base_nxt = `BANK1_BASE;
            2'b10: base_nxt = `BANK2_BASE;
            2'b11: base_nxt = `BANK3_BASE;
        endcase
        if (SFR_RD)
        begin
            if (SFR_ADDR == `ADDR_PRIMARY)
                rdata_nxt = acc_r;
            else if (SFR_ADDR == `ADDR_SECOND)
                rdata_nxt = b_r;
            else if (SFR_ADDR == `ADDR_STATUS_WORD)
                rdata_nxt = {psw_r[7:1], par_r};
            else
                rdata_nxt = `RST_BYTE;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            acc_r <= `RST_BYTE;
            b_r <= `RST_BYTE;
            psw_r <= `RST_BYTE;
            par_r <= 1'b0;
            base_r <= `BANK0_BASE;
            bres_r <= `RST_BYTE;
            jump_r <= 1'b0;
            rdata_r <= `RST_BYTE;
        end
        else
        begin
            acc_r <= acc_nxt;
            b_r <= b_nxt;
            psw_r <= psw_nxt;
            par_r <= par_nxt;
            base_r <= base_nxt;
            bres_r <= bres_nxt;
            jump_r <= jump_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign SFR_RDATA = rdata_r;
    assign BIT_RESULT = bres_r;
    assign JUMP_TAKEN = jump_r;
    assign PRIMARY_OUT = acc_r;
    assign SECOND_OUT = b_r;
    assign STATUS_OUT = {psw_r[7:1], par_r};
    assign BANK_BASE = base_r;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_jbc_req;
        op_go && (OP_CODE == OP_JBC) && OP_SRC[OP_BIT];
    endsequence
    sequence s_jbc_done;
        JUMP_TAKEN && (BIT_RESULT == ($past(OP_SRC) & ~(8'h01 << $past(OP_BIT))));
    endsequence

    a_parity_odd: assert property (STATUS_OUT[`BIT_PARITY] == ^PRIMARY_OUT)
        else $error("parity does not follow primary operand");
    a_bank_base: assert property (BANK_BASE ==
        {3'b000, STATUS_OUT[`BIT_BANK_HI:`BIT_BANK_LO], 3'b000})
        else $error("bank base mismatch");
    a_user_flags: assert property (!(SFR_WR && SFR_ADDR == `ADDR_STATUS_WORD)
        |=> $stable({psw_r[`BIT_USER_ZERO], psw_r[`BIT_USER_ONE]}))
        else $error("user flags changed without write");
    a_acc_write: assert property (SFR_WR && SFR_ADDR == `ADDR_PRIMARY
        |=> PRIMARY_OUT == $past(SFR_WDATA))
        else $error("primary write lost");
    a_add_sum: assert property (op_go && OP_CODE == OP_ADD
        |=> {STATUS_OUT[`BIT_CARRY], PRIMARY_OUT} == $past({1'b0, acc_r} + {1'b0, OP_SRC}))
        else $error("add result wrong");
    a_mul_pair: assert property (op_go && OP_CODE == OP_MUL
        |=> {SECOND_OUT, PRIMARY_OUT} == $past({8'h00, acc_r} * {8'h00, b_r}))
        else $error("multiply result wrong");
    a_div_zero: assert property (op_go && OP_CODE == OP_DIV && b_r == 8'h00
        |=> STATUS_OUT[`BIT_SIGNED_EXCESS] && $stable(acc_r) && $stable(b_r))
        else $error("divide by zero handling wrong");
    a_xor_byte: assert property (op_go && OP_CODE == OP_XOR
        |=> PRIMARY_OUT == ($past(acc_r) ^ $past(OP_SRC)))
        else $error("xor result wrong");
    a_jbc_clear: assert property (s_jbc_req |=> s_jbc_done)
        else $error("jump and clear wrong");
    a_cmp_keep: assert property (op_go && OP_CODE == OP_CMP
        |=> $stable(acc_r) && !JUMP_TAKEN
        && (STATUS_OUT[`BIT_CARRY] == $past(acc_r < OP_SRC)))
        else $error("compare changed primary");
endmodule // cpu_alu_status_datapath
`default_nettype wire
